// [include/bfc_defs.vh]
`ifndef BFC_DEFS_VH
`define BFC_DEFS_VH
// Clock and timing
`define BFC_CLK_HZ      100000000
`define BFC_RX_TO_MS    100
`define BFC_SYNC_BYTES  5'h10
`define BFC_SYNC_HALF   5'h08
`define BFC_SYNC_DIV    19'h00012
`define BFC_STOP_BIT    4'h9
// Command codes
`define BFC_CMD_PREAD   8'hFF
`define BFC_CMD_PPROG   8'h41
`define BFC_CMD_BERASE  8'h20
`define BFC_CMD_EALL    8'hA7
`define BFC_CMD_STAT    8'h70
`define BFC_CMD_CLR     8'h50
`define BFC_CMD_LKRD    8'h71
`define BFC_CMD_LKPROG  8'h77
`define BFC_CMD_LKEN    8'h7A
`define BFC_CMD_LKDIS   8'h75
`define BFC_CMD_IDCHK   8'hF5
`define BFC_CMD_DLOAD   8'hFA
`define BFC_CMD_VER     8'hFB
`define BFC_CMD_BOOTRD  8'hFC
`define BFC_CMD_CHK     8'hFD
`define BFC_CMD_BAUD    5'h16
`define BFC_CONFIRM     8'hD0
`define BFC_SYNC_ACK    8'hB0
// Transfer lengths
`define BFC_PAGE_LEN    16'h0100
`define BFC_VER_LEN     16'h0008
`define BFC_CHK_LEN     16'h0002
`define BFC_STAT_LEN    16'h0002
// Status layout and reset values
`define BFC_OPST_RST    8'h80
`define BFC_ID_NONE     2'b00
`define BFC_ID_BAD      2'b01
`define BFC_ID_OK       2'b11
`define BFC_CRC_INIT    16'h0000
`define BFC_CRC_POLY    16'h1021
// ID byte spacing from the first ID address
`define BFC_ID_OFS1     8'h04
`define BFC_ID_OFS2     8'h0C
`define BFC_ID_OFS3     8'h10
`define BFC_ID_OFS4     8'h14
`define BFC_ID_OFS5     8'h18
`define BFC_ID_OFS6     8'h1C
// Flash-side operations
`define BFC_OP_READ     4'h0
`define BFC_OP_PROG     4'h1
`define BFC_OP_BERASE   4'h2
`define BFC_OP_EALL     4'h3
`define BFC_OP_LKPROG   4'h4
`define BFC_OP_LKRD     4'h5
`define BFC_OP_LKEN     4'h6
`define BFC_OP_LKDIS    4'h7
`define BFC_OP_BOOTRD   4'h8
`define BFC_OP_RAMWR    4'h9
`endif

// [rtl/bfc_boot_port.v]
`timescale 1ns/1ns
`include "bfc_defs.vh"

// Small FIFO between the command engine and the transmitter
module bfc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             clk_in,
  input  wire             rst_n_in,
  input  wire             in_valid_in,
  output wire             in_ready_out,
  input  wire [WIDTH-1:0] in_data_in,
  output wire             out_valid_out,
  input  wire             out_ready_in,
  output wire [WIDTH-1:0] out_data_out
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wp;
  reg [AW-1:0]    rp;
  reg [AW:0]      fill;
  wire            wr = in_valid_in && in_ready_out;
  wire            rd = out_valid_out && out_ready_in;
  assign in_ready_out  = (fill != DEPTH);
  assign out_valid_out = (fill != 0);
  assign out_data_out  = mem[rp];
  // Pointers wrap naturally since depth is a power of two
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      wp   <= {AW{1'b0}};
      rp   <= {AW{1'b0}};
      fill <= {(AW+1){1'b0}};
    end else begin
      if (wr) begin
        mem[wp] <= in_data_in;
        wp      <= wp + 1'b1;
      end
      if (rd)
        rp <= rp + 1'b1;
      if (wr && !rd)
        fill <= fill + 1'b1;
      else if (rd && !wr)
        fill <= fill - 1'b1;
    end
  end
endmodule

// Function
// (RULE1) Timeout sets flag, drops command, idles
// (RULE2) ID result field; 11 unlocks gated commands
// (RULE3) Flag shows program downloaded to RAM
// (RULE4) Flag shows download checksum matched
// (RULE5) Boot mode when select pin low at reset
// (RULE6) Frames: 8 bits, LSB first, 1 stop
// (RULE7) Programmer sends sixteen zero bytes at 9600
// (RULE8) Programmer spaces sync bytes by 15 ms
// (RULE9) Send B0 after bit rate tuned
// (RULE10) Link runs 9600 bps after sync
// (RULE11) Divider from fastest first, slowest last eight
// (RULE12) Divider derived for any main clock rate
// (RULE13) Baud commands B0..B4, code sent twice
// (RULE14) Programmer waits or polls after erase/program
// (RULE15) All commands arrive on receive line
// (RULE16) Page and boot read output 256 bytes
// (RULE17) Page program takes 256 data bytes
// (RULE18) Block erase and erase-all need D0 confirm
// (RULE19) Lock status, program, enable, disable commands
// (RULE20) Download takes size, checksum, then data
// (RULE21) Version command returns eight bytes
// (RULE22) Unverified: only status, ID, version, baud
// (RULE23) ID field 00 unchecked, 01 mismatch
// (RULE24) ID check: three address bytes, length, IDs
// (RULE25) Status read returns primary then secondary
// (RULE26) Clear status clears three error bits
// (RULE27) Receive timeout length is a parameter
module bfc_boot_port #(
  parameter [31:0] RX_TIMEOUT_CYC = `BFC_RX_TO_MS * (`BFC_CLK_HZ / 1000),
  parameter [63:0] VERSION        = 64'h5645525F30303031 // Arbitrary value
) (
  input  wire        clk_in,
  input  wire        rst_n_in,
  input  wire        boot_select_pin_in,
  input  wire        serial_rx_line_in,
  output reg         serial_tx_line_out,
  output reg         boot_mode_out,
  output reg         flash_req_out,
  output reg  [3:0]  flash_op_out,
  output reg  [23:0] flash_addr_out,
  output reg  [7:0]  flash_wdata_out,
  input  wire        flash_ack_in,
  input  wire [7:0]  flash_rdata_in,
  input  wire        flash_busy_in,
  input  wire        flash_blank_in,
  input  wire        erase_err_in,
  input  wire        prog_err_in,
  input  wire        over_prog_err_in,
  output reg  [7:0]  flash_op_status_out,
  output reg  [7:0]  boot_link_status_out
);
  localparam [3:0] S_OFF = 4'h0, S_SYNC = 4'h1, S_IDLE = 4'h2, S_ARG = 4'h3,
                   S_CONF = 4'h4, S_RECV = 4'h5, S_SEND = 4'h6, S_WAIT = 4'h7,
                   S_PUSH = 4'h8, S_BAUD = 4'h9;

  reg  [3:0]  st;
  reg         strap_done;
  reg  [7:0]  cmd;
  reg  [23:0] addr;
  reg  [15:0] cnt;
  reg  [15:0] total;
  reg  [1:0]  argn;
  reg  [7:0]  obuf;
  reg  [15:0] div;
  reg  [15:0] base;
  reg  [15:0] next_div;
  reg         baud_pend;
  reg  [17:0] run;
  reg  [17:0] run_min;
  reg  [17:0] run_max;
  reg  [4:0]  nsync;
  reg  [2:0]  err;
  reg         dl_done;
  reg         sum_ok;
  reg  [1:0]  id_res;
  reg         to_flag;
  reg         id_acc;
  reg  [7:0]  csum;
  reg  [15:0] crc;
  reg  [31:0] to_cnt;
  reg  [15:0] rx_cnt;
  reg  [3:0]  rx_bit;
  reg         rx_busy;
  reg  [7:0]  rx_sh;
  reg         rx_valid;
  reg  [15:0] tx_cnt;
  reg  [3:0]  tx_bit;
  reg  [9:0]  tx_sh;
  reg         tx_busy;
  wire        f_ready;
  wire        f_valid;
  wire [7:0]  f_data;
  wire [18:0] run_sum = {1'b0, run_min} + {1'b0, run_max};
  wire [18:0] sync_div = run_sum / `BFC_SYNC_DIV;
  wire [23:0] na = {rx_sh, addr[23:8]};
  wire        id_ok = (id_res == `BFC_ID_OK) || flash_blank_in;

  // Commands usable without a verified ID
  function bfc_free;
    input [7:0] c;
    begin
      bfc_free = (c == `BFC_CMD_STAT) || (c == `BFC_CMD_IDCHK) ||
                 (c == `BFC_CMD_VER) || (c[7:3] == `BFC_CMD_BAUD && c[2:0] < 3'h5);
    end
  endfunction

  // Bit period for each baud command, relative to the tuned 9600 period
  function [15:0] bfc_baud;
    input [2:0]  c;
    input [15:0] b;
    begin
      case (c)
        3'h1:    bfc_baud = b >> 1;
        3'h2:    bfc_baud = b >> 2;
        3'h3:    bfc_baud = b / 16'h0006;
        3'h4:    bfc_baud = b / 16'h000C;
        default: bfc_baud = b;
      endcase
    end
  endfunction

  // Spacing of the scattered ID bytes
  function [7:0] bfc_id_ofs;
    input [2:0] i;
    begin
      case (i)
        3'h1:    bfc_id_ofs = `BFC_ID_OFS1;
        3'h2:    bfc_id_ofs = `BFC_ID_OFS2;
        3'h3:    bfc_id_ofs = `BFC_ID_OFS3;
        3'h4:    bfc_id_ofs = `BFC_ID_OFS4;
        3'h5:    bfc_id_ofs = `BFC_ID_OFS5;
        3'h6:    bfc_id_ofs = `BFC_ID_OFS6;
        default: bfc_id_ofs = 8'h00;
      endcase
    end
  endfunction

  // Check data over programmed bytes, MSB first
  function [15:0] bfc_crc16;
    input [15:0] c;
    input [7:0]  d;
    integer      i;
    reg   [15:0] r;
    begin
      r = c;
      for (i = 7; i >= 0; i = i - 1)
        r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? `BFC_CRC_POLY : 16'h0000);
      bfc_crc16 = r;
    end
  endfunction

  // Strap caught on the first clock after reset release
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      strap_done    <= 1'b0;
      boot_mode_out <= 1'b0;
    end else if (!strap_done) begin
      strap_done    <= 1'b1;
      boot_mode_out <= ~boot_select_pin_in; // [RULE5]
    end
  end

  // Receiver: sample mid-bit, data LSB first, stop must be high
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      rx_busy  <= 1'b0;
      rx_valid <= 1'b0;
      rx_cnt   <= 16'h0000;
      rx_bit   <= 4'h0;
      rx_sh    <= 8'h00;
    end else begin
      rx_valid <= 1'b0;
      if (st == S_OFF || st == S_SYNC) begin
        rx_busy <= 1'b0;
      end else if (!rx_busy) begin
        if (!serial_rx_line_in) begin
          rx_busy <= 1'b1;
          rx_cnt  <= {1'b0, div[15:1]};
          rx_bit  <= 4'h0;
        end
      end else if (rx_cnt != 16'h0000) begin
        rx_cnt <= rx_cnt - 16'h0001;
      end else begin
        rx_cnt <= div;
        rx_bit <= rx_bit + 4'h1;
        if (rx_bit == 4'h0 && serial_rx_line_in)
          rx_busy <= 1'b0; // False start, too short
        else if (rx_bit == `BFC_STOP_BIT) begin
          rx_busy  <= 1'b0;
          rx_valid <= serial_rx_line_in; // [RULE6] [RULE15]
        end else if (rx_bit != 4'h0)
          rx_sh <= {serial_rx_line_in, rx_sh[7:1]}; // [RULE6]
      end
    end
  end

  // Transmitter drains the FIFO; a slow line back-pressures the engine
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      tx_busy            <= 1'b0;
      tx_cnt             <= 16'h0000;
      tx_bit             <= 4'h0;
      tx_sh              <= 10'h3FF;
      serial_tx_line_out <= 1'b1;
    end else if (!tx_busy) begin
      serial_tx_line_out <= 1'b1;
      if (f_valid) begin
        tx_busy <= 1'b1;
        tx_sh   <= {1'b1, f_data, 1'b0}; // [RULE6]
        tx_cnt  <= div;
        tx_bit  <= 4'h0;
      end
    end else begin
      serial_tx_line_out <= tx_sh[0];
      if (tx_cnt != 16'h0000)
        tx_cnt <= tx_cnt - 16'h0001;
      else begin
        tx_cnt <= div;
        tx_sh  <= {1'b1, tx_sh[9:1]};
        tx_bit <= tx_bit + 4'h1;
        if (tx_bit == `BFC_STOP_BIT)
          tx_busy <= 1'b0;
      end
    end
  end

  bfc_fifo #(.WIDTH(8), .DEPTH(4), .AW(2)) u_txq (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .in_valid_in   (st == S_PUSH),
    .in_ready_out  (f_ready),
    .in_data_in    (obuf),
    .out_valid_out (f_valid),
    .out_ready_in  (!tx_busy),
    .out_data_out  (f_data)
  );

  // Command engine
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      st <= S_OFF;
      {cmd, obuf, csum, argn, nsync} <= 31'h0;
      {addr, cnt, total} <= 56'h0;
      {div, base, next_div, baud_pend} <= 49'h0;
      run <= 18'h0;
      run_min <= 18'h3FFFF;
      run_max <= 18'h0;
      {err, dl_done, sum_ok, to_flag, id_acc} <= 7'h0;
      id_res <= `BFC_ID_NONE;
      crc <= `BFC_CRC_INIT;
      to_cnt <= 32'h0;
      flash_req_out <= 1'b0;
      flash_op_out <= `BFC_OP_READ;
      flash_addr_out <= 24'h0;
      flash_wdata_out <= 8'h00;
      flash_op_status_out <= `BFC_OPST_RST;
      boot_link_status_out <= 8'h00;
    end else begin
      flash_req_out <= 1'b0;
      err <= err | {erase_err_in, prog_err_in, over_prog_err_in};
      flash_op_status_out <= {~flash_busy_in, 1'b0, err, 3'b000};
      boot_link_status_out <= {dl_done, 2'b00, sum_ok, id_res, to_flag, 1'b0};
      // Timeout only runs while a command waits for more bytes
      if ((st == S_ARG || st == S_CONF || st == S_RECV || st == S_BAUD) && !rx_valid)
        to_cnt <= to_cnt + 32'h1;
      else
        to_cnt <= 32'h0;
      if (baud_pend && st == S_IDLE && !f_valid && !tx_busy) begin
        div <= next_div; // Switch only after the echo has left
        baud_pend <= 1'b0;
      end
      if (to_cnt == RX_TIMEOUT_CYC - 32'h1) begin
        to_flag <= 1'b1; // [RULE1] [RULE27]
        st <= S_IDLE;
      end else begin
        case (st)
          S_OFF: if (strap_done && boot_mode_out) st <= S_SYNC;
          S_SYNC: begin
            // Length of each zero byte's low run gives nine bit times
            if (nsync == `BFC_SYNC_BYTES) begin
              base <= sync_div[15:0]; // [RULE11] [RULE12]
              div <= sync_div[15:0] - 16'h1; // [RULE10]
              obuf <= `BFC_SYNC_ACK; // [RULE9]
              cnt <= 16'h0;
              total <= 16'h1;
              st <= S_PUSH;
            end else if (!serial_rx_line_in)
              run <= run + 18'h1;
            else if (run != 18'h0) begin
              run <= 18'h0;
              nsync <= nsync + 5'h1;
              if (nsync < `BFC_SYNC_HALF && run < run_min)
                run_min <= run; // [RULE11]
              if (nsync >= `BFC_SYNC_HALF && run > run_max)
                run_max <= run; // [RULE11]
            end
          end
          S_IDLE: if (rx_valid) begin
            cmd <= rx_sh;
            cnt <= 16'h0;
            total <= 16'h0;
            addr <= 24'h0;
            csum <= 8'h00;
            id_acc <= 1'b1;
            argn <= 2'h2;
            if (!id_ok && !bfc_free(rx_sh)) begin
              st <= S_IDLE; // [RULE22] [RULE2]
            end else begin
              case (rx_sh)
                `BFC_CMD_PREAD, `BFC_CMD_BOOTRD, `BFC_CMD_LKRD, `BFC_CMD_PPROG,
                `BFC_CMD_BERASE, `BFC_CMD_LKPROG:
                  if (rx_sh == `BFC_CMD_PREAD || rx_sh == `BFC_CMD_BOOTRD ||
                      rx_sh == `BFC_CMD_LKRD || err == 3'h0) st <= S_ARG;
                `BFC_CMD_IDCHK, `BFC_CMD_DLOAD: begin
                  argn <= 2'h3; // [RULE24] [RULE20]
                  st <= S_ARG;
                end
                `BFC_CMD_EALL: if (err == 3'h0) st <= S_CONF; // [RULE18]
                `BFC_CMD_STAT: begin
                  obuf <= flash_op_status_out; // [RULE25]
                  total <= `BFC_STAT_LEN;
                  st <= S_PUSH;
                end
                `BFC_CMD_VER: begin
                  total <= `BFC_VER_LEN; // [RULE21]
                  st <= S_SEND;
                end
                `BFC_CMD_CHK: begin
                  total <= `BFC_CHK_LEN;
                  st <= S_SEND;
                end
                `BFC_CMD_CLR: begin
                  err <= {erase_err_in, prog_err_in, over_prog_err_in}; // [RULE26]
                  to_flag <= 1'b0;
                end
                `BFC_CMD_LKEN, `BFC_CMD_LKDIS: begin
                  flash_op_out <= (rx_sh == `BFC_CMD_LKEN) ? `BFC_OP_LKEN
                                                         : `BFC_OP_LKDIS; // [RULE19]
                  flash_req_out <= 1'b1;
                  st <= S_WAIT;
                end
                default: if (bfc_free(rx_sh) && rx_sh[7:3] == `BFC_CMD_BAUD)
                  st <= S_BAUD; // [RULE13]
              endcase
            end
          end
          S_ARG: if (rx_valid) begin
            addr <= na;
            argn <= argn - 2'h1;
            if (argn == 2'h1) begin
              case (cmd)
                `BFC_CMD_PREAD, `BFC_CMD_BOOTRD: begin
                  total <= `BFC_PAGE_LEN; // [RULE16]
                  st <= S_SEND;
                end
                `BFC_CMD_LKRD: begin
                  total <= 16'h1; // [RULE19]
                  st <= S_SEND;
                end
                `BFC_CMD_PPROG: begin
                  total <= `BFC_PAGE_LEN; // [RULE17]
                  st <= S_RECV;
                end
                `BFC_CMD_DLOAD: begin
                  total <= addr[23:8]; // [RULE20]
                  st <= (addr[23:8] == 16'h0) ? S_IDLE : S_RECV;
                end
                `BFC_CMD_IDCHK: st <= S_RECV; // [RULE24]
                default: st <= S_CONF;
              endcase
            end
          end
          S_CONF: if (rx_valid) begin
            if (rx_sh == `BFC_CONFIRM) begin
              flash_op_out <= (cmd == `BFC_CMD_EALL) ? `BFC_OP_EALL :
                              (cmd == `BFC_CMD_BERASE) ? `BFC_OP_BERASE
                                                       : `BFC_OP_LKPROG; // [RULE18] [RULE19]
              flash_addr_out <= addr;
              flash_req_out <= 1'b1;
              st <= S_WAIT;
            end else
              st <= S_IDLE;
          end
          S_RECV: if (rx_valid) begin
            flash_wdata_out <= rx_sh;
            if (cmd == `BFC_CMD_IDCHK && total == 16'h0) begin
              total <= {8'h00, rx_sh}; // ID length byte
              if (rx_sh == 8'h00) st <= S_IDLE;
            end else begin
              flash_req_out <= 1'b1;
              st <= S_WAIT;
              case (cmd)
                `BFC_CMD_IDCHK: begin
                  flash_op_out <= `BFC_OP_READ;
                  flash_addr_out <= addr + {16'h0, bfc_id_ofs(cnt[2:0])};
                end
                `BFC_CMD_PPROG: begin
                  flash_op_out <= `BFC_OP_PROG; // [RULE17]
                  flash_addr_out <= {addr[23:8], cnt[7:0]};
                  crc <= bfc_crc16(crc, rx_sh);
                end
                default: begin
                  flash_op_out <= `BFC_OP_RAMWR; // [RULE20]
                  flash_addr_out <= {8'h00, cnt};
                  csum <= csum + rx_sh;
                end
              endcase
            end
          end
          S_SEND: begin
            if (cmd == `BFC_CMD_VER) begin
              obuf <= VERSION[8'd63 - {cnt[2:0], 3'b000} -: 8]; // [RULE21]
              st <= S_PUSH;
            end else if (cmd == `BFC_CMD_CHK) begin
              obuf <= cnt[0] ? crc[15:8] : crc[7:0];
              st <= S_PUSH;
            end else begin
              flash_op_out <= (cmd == `BFC_CMD_LKRD) ? `BFC_OP_LKRD :
                              (cmd == `BFC_CMD_BOOTRD) ? `BFC_OP_BOOTRD
                                                       : `BFC_OP_READ; // [RULE16]
              flash_addr_out <= {addr[23:8], cnt[7:0]};
              flash_req_out <= 1'b1;
              st <= S_WAIT;
            end
          end
          S_WAIT: if (flash_ack_in) begin
            case (cmd)
              `BFC_CMD_PREAD, `BFC_CMD_BOOTRD, `BFC_CMD_LKRD: begin
                obuf <= flash_rdata_in;
                st <= S_PUSH;
              end
              `BFC_CMD_IDCHK, `BFC_CMD_PPROG, `BFC_CMD_DLOAD: begin
                cnt <= cnt + 16'h1;
                st <= (cnt + 16'h1 == total) ? S_IDLE : S_RECV;
                if (cmd == `BFC_CMD_IDCHK && cnt + 16'h1 == total)
                  id_res <= (id_acc && flash_rdata_in == flash_wdata_out) ?
                            `BFC_ID_OK : `BFC_ID_BAD; // [RULE2] [RULE23]
                else if (cmd == `BFC_CMD_IDCHK)
                  id_acc <= id_acc && (flash_rdata_in == flash_wdata_out);
                if (cmd == `BFC_CMD_DLOAD && cnt + 16'h1 == total) begin
                  dl_done <= 1'b1; // [RULE3]
                  sum_ok <= (csum == addr[23:16]); // [RULE4]
                end
              end
              default: st <= S_IDLE;
            endcase
          end
          S_PUSH: if (f_ready) begin
            cnt <= cnt + 16'h1;
            if (cnt + 16'h1 == total) begin
              st <= S_IDLE;
              if (cmd == `BFC_CMD_CHK) crc <= `BFC_CRC_INIT;
            end else if (cmd == `BFC_CMD_STAT)
              obuf <= boot_link_status_out; // [RULE25]
            else
              st <= S_SEND;
          end
          S_BAUD: if (rx_valid) begin
            if (rx_sh == cmd) begin
              next_div <= bfc_baud(cmd[2:0], base) - 16'h1; // [RULE13]
              baud_pend <= 1'b1;
              obuf <= cmd;
              total <= 16'h1;
              st <= S_PUSH;
            end else
              st <= S_IDLE;
          end
          default: st <= S_IDLE;
        endcase
      end
    end
  end
endmodule

// [verification/bfc_boot_port_monitor.sv]
`timescale 1ns/1ns
// Pin-level checks on the boot command port
module bfc_boot_port_monitor (
  input wire logic       clk_in,
  input wire logic       rst_n_in,
  input wire logic       boot_select_pin_in,
  input wire logic       boot_mode_out,
  input wire logic       flash_req_out,
  input wire logic [3:0] flash_op_out,
  input wire logic       flash_blank_in,
  input wire logic       prog_err_in,
  input wire logic       flash_busy_in,
  input wire logic [7:0] flash_op_status_out,
  input wire logic [7:0] boot_link_status_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  // Strap is taken on the first edge after release
  a_boot_mode_on:
    assert property ($rose(rst_n_in) && !boot_select_pin_in |=> boot_mode_out)
    else $error("boot mode not entered");
  a_id_field_legal:
    assert property (boot_link_status_out[3:2] != 2'b10)
    else $error("reserved id result code");
  // Only reads may run before the id is verified, since id compare itself reads
  a_gate_needs_id:
    assert property (flash_req_out && flash_op_out != 4'h0 && !flash_blank_in
      |-> boot_link_status_out[3:2] == 2'b11)
    else $error("gated flash op before id verified");
  a_err_blocks_write:
    assert property (flash_req_out && flash_op_out inside {4'h1, 4'h2, 4'h3, 4'h4}
      |-> flash_op_status_out[5:3] == 3'b000)
    else $error("write op started with error bits set");
  a_err_sticky_set:
    assert property ($rose(prog_err_in) |-> ##[1:3] flash_op_status_out[4])
    else $error("program error bit not set");
  a_status_reserved:
    assert property (flash_op_status_out[6] == 1'b0 && flash_op_status_out[2:0] == 3'h0
      && boot_link_status_out[6:5] == 2'h0 && boot_link_status_out[0] == 1'b0)
    else $error("reserved status bit set");
  a_sum_with_done:
    assert property ($rose(boot_link_status_out[4]) |-> ##[0:2] boot_link_status_out[7])
    else $error("checksum flag without download flag");
  a_ready_tracks_busy:
    assert property (flash_busy_in [*3] |-> !flash_op_status_out[7])
    else $error("ready shown while flash busy");
  a_req_one_cycle:
    assert property (flash_req_out |=> !flash_req_out)
    else $error("flash request longer than one cycle");
endmodule

// [verification/bfc_flash_model.sv]
`timescale 1ns/1ns
// Flash array stand-in; data is only valid with the ack, stale data is inverted
module bfc_flash_model (
  input  wire logic        clk_in,
  input  wire logic        req_in,
  input  wire logic [23:0] addr_in,
  output logic             ack_out,
  output logic [7:0]       rdata_out,
  output logic             busy_out
);
  logic [2:0] cnt = 3'h0;
  logic [7:0] addr_q = 8'h00;
  initial begin
    ack_out = 1'b0;
    rdata_out = 8'h00;
    busy_out = 1'b0;
  end
  // Each op ends three cycles after its request
  always @(posedge clk_in) begin
    ack_out <= (cnt == 3'h1);
    rdata_out <= (cnt == 3'h1) ? (addr_q ^ 8'hA5) : ~rdata_out;
    busy_out <= req_in || cnt > 3'h1;
    if (req_in) begin
      cnt <= 3'h3;
      addr_q <= addr_in[7:0];
    end else if (cnt != 3'h0) begin
      cnt <= cnt - 3'h1;
    end
  end
endmodule

// [verification/uart_flash_boot_command_port_test.sv]
`timescale 1ns/1ns
module uart_flash_boot_command_port_test;
  localparam int P = 16;
  localparam [63:0] VER = 64'h0123456789ABCDEF; // Arbitrary value
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic rx = 1'b1;
  logic perr = 1'b0;
  logic operr = 1'b0;
  logic sync = 1'b0;
  wire tx, req, ack, busy, mode;
  wire [23:0] addr;
  wire [7:0] rd, wd;
  int err_count = 0;
  int checked = 0;
  int nreq = 0;
  logic [7:0] q[$];
  logic [7:0] e[$];

  always #5 clk_in = ~clk_in;
  // Count flash requests to see which commands really ran
  always @(posedge clk_in) if (req === 1'b1) nreq++;

  bfc_boot_port #(.RX_TIMEOUT_CYC(32'd2000), .VERSION(VER)) dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .boot_select_pin_in(1'b0),
    .serial_rx_line_in(rx), .serial_tx_line_out(tx), .boot_mode_out(mode),
    .flash_req_out(req), .flash_op_out(), .flash_addr_out(addr), .flash_wdata_out(wd),
    .flash_ack_in(ack), .flash_rdata_in(rd), .flash_busy_in(busy),
    .flash_blank_in(1'b0), .erase_err_in(1'b0), .prog_err_in(perr),
    .over_prog_err_in(operr), .flash_op_status_out(), .boot_link_status_out());
  bfc_flash_model flash (.clk_in(clk_in), .req_in(req), .addr_in(addr), .ack_out(ack),
    .rdata_out(rd), .busy_out(busy));

  task cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Sync bytes stretch the low run a little so the divider never rounds down
  task send(input logic [7:0] b);
    if (sync) begin
      @(posedge clk_in) #1 rx = 1'b0;
      repeat (148) @(posedge clk_in);
      #1 rx = 1'b1;
      repeat (40) @(posedge clk_in);
    end else begin
      for (int i = 0; i < 10; i++) begin
        @(posedge clk_in) #1 rx = (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i - 1];
        repeat (P - 1) @(posedge clk_in);
      end
    end
  endtask
  task getb(output logic [7:0] b);
    int n;
    n = 0;
    while (tx !== 1'b0 && n < 4000) begin
      @(posedge clk_in);
      n++;
    end
    if (n == 4000) cmp8("tx start", 8'h00, {7'h0, tx});
    repeat (P / 2) @(posedge clk_in);
    for (int i = 0; i < 8; i++) begin
      repeat (P) @(posedge clk_in);
      b[i] = tx;
    end
    repeat (P) @(posedge clk_in);
    cmp8("stop bit", 8'h01, {7'h0, tx});
  endtask
  // Answers may start before the last stop bit ends, so listen while sending
  task talk(input string what);
    logic [7:0] g;
    fork
      foreach (q[i]) send(q[i]);
      foreach (e[i]) begin
        getb(g);
        cmp8(what, e[i], g);
      end
    join
    q = {};
    e = {};
    repeat (4 * P) @(posedge clk_in);
    $display("test %s done", what);
  endtask
  task status(input logic [7:0] o, input logic [7:0] l);
    q = {8'h70};
    e = {o, l};
    talk("status");
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Byte gaps in sync are far below 15 ms to keep the run short
  initial begin
    repeat (20) @(posedge clk_in);
    #1 rst_n_in = 1'b1;
    repeat (3) @(posedge clk_in);
    cmp8("boot mode", 8'h01, {7'h0, mode});
    sync = 1'b1;
    repeat (16) q.push_back(8'h00);
    e = {8'hB0};
    talk("sync");
    sync = 1'b0;
    status(8'h80, 8'h00);
    q = {8'h7A};
    talk("gated");
    cmp8("gated req", 8'h00, nreq[7:0]);
    q = {8'hF5, 8'h00};
    talk("partial");
    repeat (2500) @(posedge clk_in);
    status(8'h80, 8'h02);
    q = {8'hF5, 8'h00, 8'h12, 8'h00, 8'h01, 8'h00};
    talk("bad id");
    status(8'h80, 8'h06);
    q = {8'hF5, 8'h00, 8'h12, 8'h00, 8'h01, 8'hA5};
    talk("good id");
    status(8'h80, 8'h0E);
    q = {8'hFF, 8'h12, 8'h00};
    for (int i = 0; i < 256; i++) e.push_back(i[7:0] ^ 8'hA5);
    talk("page read");
    q = {8'h71, 8'h12, 8'h00};
    e = {8'hA5};
    talk("lock read");
    nreq = 0;
    q = {8'h7A};
    talk("lock enable");
    cmp8("lock req", 8'h01, nreq[7:0]);
    @(posedge clk_in) #1 {perr, operr} = 2'b11;
    @(posedge clk_in) #1 {perr, operr} = 2'b00;
    status(8'h98, 8'h0E);
    // Set program and over-program error bits must hold back erase-all
    nreq = 0;
    q = {8'hA7, 8'hD0};
    talk("erase blocked");
    cmp8("erase req", 8'h00, nreq[7:0]);
    q = {8'h50};
    talk("clear");
    status(8'h80, 8'h0C);
    q = {8'hA7, 8'hD0};
    talk("erase all");
    cmp8("erase req", 8'h01, nreq[7:0]);
    q = {8'hFA, 8'h02, 8'h00, 8'h46, 8'h12, 8'h34};
    talk("download");
    cmp8("ram data", 8'h34, wd);
    status(8'h80, 8'h9C);
    for (int i = 7; i >= 0; i--) e.push_back(VER[8 * i +: 8]);
    q = {8'hFB};
    talk("version");
    report_and_stop;
  end
  // The tests need about 60000 cycles; twice that means a hang
  initial begin
    repeat (120000) @(posedge clk_in);
    err_count++;
    report_and_stop;
  end
endmodule

bind bfc_boot_port bfc_boot_port_monitor mon (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .boot_select_pin_in(boot_select_pin_in),
  .boot_mode_out(boot_mode_out), .flash_req_out(flash_req_out),
  .flash_op_out(flash_op_out), .flash_blank_in(flash_blank_in),
  .prog_err_in(prog_err_in), .flash_busy_in(flash_busy_in),
  .flash_op_status_out(flash_op_status_out), .boot_link_status_out(boot_link_status_out));
